// ==== hw/ivs_top.sv ====
/*
 Interrupt vector table select: resolves pending requests by natural order,
 and hands the CPU the vector number and table entry address to fetch.
 Also gives the reset entry point, which bypasses vector fetching.
 Assumes pending/enable/priority filtering happens before irq_pending, and
 that all inputs come from logic on sys_clk.
*/
// Behaviour
// - Select bit set makes every vector come from the alternate table.
// - Alternate table follows the default with identical order and spacing.
// - Reset is not an exception; no vector is fetched for it.
// - Reset clears registers and forces the program counter to zero.
// - External interrupt zero: request 0, vector 8, entries 0x014 and 0x114.
// - Capture one: request 1, vector 9, entries 0x016 and 0x116.
// - DMA channel zero: request 4, vector 12, entry 0x01c.
// - Serial one receive: request 11, vector 19, entries 0x02a and 0x12a.
// - Entries hold 24-bit handler addresses; default table starts at 0x000004.
// - Lower vector positions win when requests are otherwise equal.
`timescale 1ns/1ps
module ivs_top (
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic [54:0] irq_pending,
   input wire logic ctrl_two_we,
   input wire logic [15:0] ctrl_two_wdata,
   input wire logic vec_ack,
   output logic [15:0] irq_control_two_q,
   output logic vec_valid_q,
   output logic [6:0] request_number_q,
   output logic [6:0] vector_number_q,
   output logic [23:0] vec_addr_q,
   output logic [23:0] program_counter_q,
   output logic in_reset_q
);
   ivs_pkg::ivs_state_t state_q;
   logic found;
   logic [6:0] win_req;
   logic [6:0] map_vec;
   logic [23:0] map_addr;
   logic alt_table_select;

   assign alt_table_select = irq_control_two_q[ivs_pkg::SEL_BIT];

   // Natural order: scan from the top so the lowest index is left standing
   always_comb begin
      found = 1'b0;
      win_req = 7'h00;
      for (int i = 54; i >= 0; i--) begin
         if (irq_pending[i]) begin
            found = 1'b1;
            win_req = 7'(i);
         end
      end
   end

   ivs_addr_map u_map (
      .request_number(win_req),
      .alt_table_select(alt_table_select),
      .vector_number(map_vec),
      .entry_addr(map_addr)
   );

   // Control register; only the select bit is implemented here
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         irq_control_two_q <= ivs_pkg::CTRL_TWO_RESET;
      end else if (ctrl_two_we) begin
         irq_control_two_q <= 16'h0000;
         irq_control_two_q[ivs_pkg::SEL_BIT] <= ctrl_two_wdata[ivs_pkg::SEL_BIT];
      end
   end

   // Reset entry: the program counter starts at zero with no table lookup
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         program_counter_q <= ivs_pkg::RESET_PC;
         in_reset_q <= 1'b1;
      end else begin
         in_reset_q <= 1'b0;
         if (state_q == ivs_pkg::IVS_PRESENT && vec_ack) begin
            program_counter_q <= vec_addr_q;
         end
      end
   end

   // Vector presentation: hold the answer stable until the core takes it
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         state_q <= ivs_pkg::IVS_IDLE;
         vec_valid_q <= 1'b0;
         request_number_q <= 7'h00;
         vector_number_q <= 7'h00;
         vec_addr_q <= 24'h000000;
      end else begin
         case (state_q)
            ivs_pkg::IVS_IDLE: begin
               // The cycle after reset release is never a vector fetch
               if (!in_reset_q && found) begin
                  state_q <= ivs_pkg::IVS_RESOLVE;
               end
            end
            ivs_pkg::IVS_RESOLVE: begin
               if (found) begin
                  request_number_q <= win_req;
                  vector_number_q <= map_vec;
                  vec_addr_q <= map_addr;
                  vec_valid_q <= 1'b1;
                  state_q <= ivs_pkg::IVS_PRESENT;
               end else begin
                  state_q <= ivs_pkg::IVS_IDLE;
               end
            end
            ivs_pkg::IVS_PRESENT: begin
               if (vec_ack) begin
                  vec_valid_q <= 1'b0;
                  state_q <= ivs_pkg::IVS_IDLE;
               end
            end
            default: begin
               state_q <= ivs_pkg::IVS_IDLE;
               vec_valid_q <= 1'b0;
            end
         endcase
      end
   end

   property p_vec_num;
      @(posedge sys_clk) disable iff (!arst_n)
      $rose(vec_valid_q) |-> vector_number_q == request_number_q + ivs_pkg::VEC_OFFSET;
   endproperty
   a_vec_num: assert property (p_vec_num) else $error("vector number mismatch");

   property p_table_addr;
      @(posedge sys_clk) disable iff (!arst_n)
      $rose(vec_valid_q) |-> vec_addr_q == 24'h000014 + {16'h0000, request_number_q, 1'b0}
         + ($past(irq_control_two_q[ivs_pkg::SEL_BIT]) ? 24'h000100 : 24'h000000);
   endproperty
   a_table_addr: assert property (p_table_addr) else $error("entry address wrong");

   property p_alt_span;
      @(posedge sys_clk) disable iff (!arst_n)
      $rose(vec_valid_q) && $past(irq_control_two_q[ivs_pkg::SEL_BIT]) |-> vec_addr_q[8];
   endproperty
   a_alt_span: assert property (p_alt_span) else $error("alternate table not used");

   property p_dma_chan_zero_irq;
      @(posedge sys_clk) disable iff (!arst_n)
      $rose(vec_valid_q) && request_number_q == 7'h04 && !$past(irq_control_two_q[ivs_pkg::SEL_BIT])
         |-> vector_number_q == 7'h0c && vec_addr_q == 24'h00001c;
   endproperty
   a_dma_chan_zero_irq: assert property (p_dma_chan_zero_irq) else $error("dma zero entry wrong");

   property p_rx1;
      @(posedge sys_clk) disable iff (!arst_n)
      $rose(vec_valid_q) && request_number_q == 7'h0b && $past(irq_control_two_q[ivs_pkg::SEL_BIT])
         |-> vector_number_q == 7'h13 && vec_addr_q == 24'h00012a;
   endproperty
   a_rx1: assert property (p_rx1) else $error("serial rx entry wrong");

   property p_cap1;
      @(posedge sys_clk) disable iff (!arst_n)
      $rose(vec_valid_q) && request_number_q == 7'h01
         |-> vec_addr_q == ($past(irq_control_two_q[ivs_pkg::SEL_BIT]) ? 24'h000116 : 24'h000016);
   endproperty
   a_cap1: assert property (p_cap1) else $error("capture one entry wrong");

   property p_prio;
      @(posedge sys_clk) disable iff (!arst_n)
      state_q == ivs_pkg::IVS_RESOLVE && irq_pending[0] |=> request_number_q == 7'h00 && vec_valid_q;
   endproperty
   a_prio: assert property (p_prio) else $error("lowest request did not win");

   property p_no_fetch_reset;
      @(posedge sys_clk) disable iff (!arst_n)
      in_reset_q |-> !vec_valid_q && program_counter_q == 24'h000000 && !irq_control_two_q[15];
   endproperty
   a_no_fetch_reset: assert property (p_no_fetch_reset) else $error("vector during reset");

   property p_hold;
      @(posedge sys_clk) disable iff (!arst_n)
      vec_valid_q && !vec_ack |=> vec_valid_q && $stable(vec_addr_q);
   endproperty
   a_hold: assert property (p_hold) else $error("vector dropped before ack");

   property p_pc_load;
      @(posedge sys_clk) disable iff (!arst_n)
      vec_valid_q && vec_ack |=> program_counter_q == $past(vec_addr_q) && !vec_valid_q;
   endproperty
   a_pc_load: assert property (p_pc_load) else $error("program counter not loaded");

   // Nothing of lower index may stand pending beside the chosen request
   property p_natural;
      @(posedge sys_clk) disable iff (!arst_n)
      state_q == ivs_pkg::IVS_RESOLVE && found
         |=> ($past(irq_pending) & ((55'h1 << request_number_q) - 55'h1)) == 55'h0;
   endproperty
   a_natural: assert property (p_natural) else $error("a lower request was passed over");

   property p_ctrl_write;
      @(posedge sys_clk) disable iff (!arst_n)
      ctrl_two_we |=> irq_control_two_q[ivs_pkg::SEL_BIT] == $past(ctrl_two_wdata[ivs_pkg::SEL_BIT]);
   endproperty
   a_ctrl_write: assert property (p_ctrl_write) else $error("select bit not stored");

   // Only the select bit is kept; the rest must read back as zero
   property p_ctrl_clear;
      @(posedge sys_clk) disable iff (!arst_n)
      irq_control_two_q[14:0] == 15'h0000;
   endproperty
   a_ctrl_clear: assert property (p_ctrl_clear) else $error("unused control bits set");

   property p_reset_release;
      @(posedge sys_clk) disable iff (!arst_n)
      $fell(in_reset_q) |-> program_counter_q == ivs_pkg::RESET_PC && !vec_valid_q;
   endproperty
   a_reset_release: assert property (p_reset_release) else $error("counter not zero after reset");

   property p_reset_idle;
      @(posedge sys_clk) disable iff (!arst_n)
      in_reset_q |=> state_q == ivs_pkg::IVS_IDLE;
   endproperty
   a_reset_idle: assert property (p_reset_idle) else $error("resolve started during reset");

   c_alt: cover property (@(posedge sys_clk) disable iff (!arst_n) $rose(vec_valid_q) && irq_control_two_q[15]);
   c_def: cover property (@(posedge sys_clk) disable iff (!arst_n) $rose(vec_valid_q) && !irq_control_two_q[15]);
   c_multi: cover property (@(posedge sys_clk) disable iff (!arst_n) $rose(vec_valid_q) && $countones(irq_pending) > 1);
   c_slow_ack: cover property (@(posedge sys_clk) disable iff (!arst_n)
      vec_valid_q && !vec_ack ##1 vec_valid_q && !vec_ack ##1 vec_ack);
endmodule

// ==== hw/ivs_pkg.sv ====
/*
 Constants for the interrupt vector table select block: vector numbering,
 table base addresses, entry spacing and reset values.
 Assumes a CPU core that fetches handler addresses from program memory.
*/
package ivs_pkg;
   localparam int unsigned REQ_W = 7;
   localparam int unsigned VEC_W = 7;
   localparam int unsigned ADDR_W = 24;
   localparam logic [6:0] NUM_REQ = 7'h37;
   localparam logic [6:0] VEC_OFFSET = 7'h08;
   localparam logic [23:0] DEF_TABLE_BASE = 24'h000004;
   localparam logic [23:0] ALT_TABLE_SPAN = 24'h000100;
   localparam int unsigned ENTRY_SHIFT = 1;
   localparam logic [23:0] RESET_PC = 24'h000000;
   localparam int unsigned SEL_BIT = 15;
   localparam logic [15:0] CTRL_TWO_RESET = 16'h0000;
   localparam logic [6:0] REQ_EXT_ZERO = 7'h00;
   localparam logic [6:0] REQ_CAPTURE_ONE = 7'h01;
   localparam logic [6:0] REQ_DMA_ZERO = 7'h04;
   localparam logic [6:0] REQ_SERIAL_ONE_RX = 7'h0b;
   typedef enum logic [1:0] {
      IVS_IDLE = 2'b00,
      IVS_RESOLVE = 2'b01,
      IVS_PRESENT = 2'b10
   } ivs_state_t;
endpackage

// ==== hw/ivs_addr_map.sv ====
/*
 Combinational map from a request number to its vector number and the
 program-memory location of its entry in either table.
 Assumes request numbers below the implemented source count.
*/
`timescale 1ns/1ps
module ivs_addr_map (
   input wire logic [6:0] request_number,
   input wire logic alt_table_select,
   output logic [6:0] vector_number,
   output logic [23:0] entry_addr
);
   logic [23:0] def_addr;
   always_comb begin
      vector_number = request_number + ivs_pkg::VEC_OFFSET;
      // Each entry is two address units wide
      def_addr = ivs_pkg::DEF_TABLE_BASE + {16'h0000, vector_number, 1'b0};
      // Same layout, whole table shifted above the default one
      entry_addr = alt_table_select ? def_addr + ivs_pkg::ALT_TABLE_SPAN : def_addr;
   end
endmodule

// ==== verif/ivs_core_model.sv ====
/*
 Core vector-fetch model: takes each presented vector after a set delay and
 returns the handler address stored at that entry of program memory.
 Assumes the presentation holds until the acknowledge pulse is seen.
*/
`timescale 1ns/1ps
module ivs_core_model #(
   parameter logic [23:0] HANDLER_BASE = 24'h001000,
   parameter logic [23:0] RESET_HANDLER = 24'h000800
) (
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic vec_valid_q,
   input wire logic [23:0] vec_addr_q,
   input wire logic [3:0] ack_delay,
   output logic vec_ack,
   output logic [23:0] handler_q
);
   logic [3:0] wait_q;
   logic [23:0] prog_mem [0:255];
   // Program memory filled the way software is expected to fill both tables
   initial begin
      for (int k = 0; k < 256; k++) prog_mem[k] = RESET_HANDLER;
      prog_mem[8'h0a] = HANDLER_BASE + 24'h000008;
      prog_mem[8'h0b] = HANDLER_BASE + 24'h000009;
      prog_mem[8'h0e] = HANDLER_BASE + 24'h00000c;
      prog_mem[8'h15] = HANDLER_BASE + 24'h000013;
      // The alternate table carries no environment of its own here
      for (int k = 0; k < 128; k++) prog_mem[k + 128] = prog_mem[k];
   end
   // One-cycle pulse; the delay lets the bench play a slow core
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         vec_ack <= 1'b0;
         wait_q <= 4'h0;
         handler_q <= 24'h000000;
      end else if (vec_valid_q && !vec_ack && wait_q == ack_delay) begin
         vec_ack <= 1'b1;
         wait_q <= 4'h0;
         handler_q <= prog_mem[vec_addr_q[8:1]];
      end else begin
         vec_ack <= 1'b0;
         wait_q <= (vec_valid_q && !vec_ack) ? wait_q + 4'h1 : 4'h0;
      end
   end
endmodule

// ==== verif/ivs_top_tb.sv ====
/*
 Self-checking bench for the vector table select block.
 Assumes the core model acknowledges vectors and the bench drives the rest.
*/
`timescale 1ns/1ps
module ivs_top_tb;
   logic sys_clk = 1'b0;
   logic arst_n = 1'b0;
   logic [54:0] irq_pending = '0;
   logic ctrl_two_we = 1'b0;
   logic [15:0] ctrl_two_wdata = 16'h0000;
   logic [3:0] ack_delay = 4'h0;
   logic vec_ack, vec_valid_q, in_reset_q;
   logic [15:0] irq_control_two_q;
   logic [6:0] request_number_q, vector_number_q;
   logic [23:0] vec_addr_q, program_counter_q;
   logic [23:0] handler_q;
   // Arbitrary handler locations for the core model's program memory
   localparam logic [23:0] HANDLER_BASE = 24'h001000;
   localparam logic [23:0] RESET_HANDLER = 24'h000800;
   int n_fail = 0;
   int check_count = 0;
   always #2.5 sys_clk = ~sys_clk;
   ivs_top i_ivs_top (.sys_clk(sys_clk), .arst_n(arst_n), .irq_pending(irq_pending),
      .ctrl_two_we(ctrl_two_we), .ctrl_two_wdata(ctrl_two_wdata), .vec_ack(vec_ack),
      .irq_control_two_q(irq_control_two_q), .vec_valid_q(vec_valid_q),
      .request_number_q(request_number_q), .vector_number_q(vector_number_q),
      .vec_addr_q(vec_addr_q), .program_counter_q(program_counter_q), .in_reset_q(in_reset_q));
   ivs_core_model #(.HANDLER_BASE(HANDLER_BASE), .RESET_HANDLER(RESET_HANDLER)) i_ivs_core_model (
      .sys_clk(sys_clk), .arst_n(arst_n), .vec_valid_q(vec_valid_q), .vec_addr_q(vec_addr_q),
      .ack_delay(ack_delay), .vec_ack(vec_ack), .handler_q(handler_q));
   task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic complete_run;
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic wr_ctrl(input logic [15:0] d, input logic [15:0] exp);
      @(posedge sys_clk);
      ctrl_two_we <= 1'b1;
      ctrl_two_wdata <= d;
      @(posedge sys_clk);
      ctrl_two_we <= 1'b0;
      @(negedge sys_clk);
      chk("control two", {8'h00, exp}, {8'h00, irq_control_two_q});
   endtask
   // Raise requests, check the presented vector, let the core take it
   task automatic serve(input logic [54:0] pend, input logic [6:0] req, input logic [6:0] vec,
      input logic [23:0] addr, input logic [23:0] hnd, input logic [3:0] dly);
      int i;
      @(posedge sys_clk);
      irq_pending <= pend;
      ack_delay <= dly;
      for (i = 0; i < 20 && vec_valid_q !== 1'b1; i++) @(negedge sys_clk);
      chk("valid seen", 24'h1, {23'h0, vec_valid_q});
      chk("request number", {17'h0, req}, {17'h0, request_number_q});
      chk("vector number", {17'h0, vec}, {17'h0, vector_number_q});
      chk("entry address", addr, vec_addr_q);
      @(posedge sys_clk);
      irq_pending <= pend & ~(55'h1 << req);
      for (i = 0; i < 20 && vec_ack !== 1'b1; i++) @(negedge sys_clk);
      @(negedge sys_clk);
      chk("program counter", addr, program_counter_q);
      chk("valid after ack", 24'h0, {23'h0, vec_valid_q});
      chk("handler", hnd, handler_q);
   endtask
   // A request that vanishes before resolve must leave no vector behind
   task automatic drop_check;
      @(posedge sys_clk);
      irq_pending <= 55'h1;
      @(posedge sys_clk);
      irq_pending <= '0;
      repeat (4) begin
         @(negedge sys_clk);
         chk("dropped request", 24'h0, {23'h0, vec_valid_q});
      end
   endtask
   task automatic reset_checks;
      chk("reset counter", 24'h000000, program_counter_q);
      chk("reset control", 24'h0, {8'h00, irq_control_two_q});
      chk("reset valid", 24'h0, {23'h0, vec_valid_q});
   endtask
   initial begin
      repeat (6) @(posedge sys_clk);
      arst_n <= 1'b1;
      @(negedge sys_clk);
      reset_checks();
      serve(55'h1, 7'h00, 7'h08, 24'h000014, HANDLER_BASE + 24'h000008, 4'h0);
      serve(55'h2, 7'h01, 7'h09, 24'h000016, HANDLER_BASE + 24'h000009, 4'h0);
      serve(55'h10, 7'h04, 7'h0c, 24'h00001c, HANDLER_BASE + 24'h00000c, 4'h5);
      serve(55'h800, 7'h0b, 7'h13, 24'h00002a, HANDLER_BASE + 24'h000013, 4'h2);
      serve(55'h8000, 7'h0f, 7'h17, 24'h000032, RESET_HANDLER, 4'h1);
      drop_check();
      wr_ctrl(16'hffff, 16'h8000);
      serve(55'h1, 7'h00, 7'h08, 24'h000114, HANDLER_BASE + 24'h000008, 4'h0);
      serve(55'h2, 7'h01, 7'h09, 24'h000116, HANDLER_BASE + 24'h000009, 4'h3);
      serve(55'h800, 7'h0b, 7'h13, 24'h00012a, HANDLER_BASE + 24'h000013, 4'h0);
      serve(55'h810, 7'h04, 7'h0c, 24'h00011c, HANDLER_BASE + 24'h00000c, 4'h1);
      serve(55'h800, 7'h0b, 7'h13, 24'h00012a, HANDLER_BASE + 24'h000013, 4'h0);
      @(posedge sys_clk);
      irq_pending <= 55'h1;
      for (int i = 0; i < 20 && vec_valid_q !== 1'b1; i++) @(negedge sys_clk);
      @(posedge sys_clk);
      arst_n <= 1'b0;
      irq_pending <= '0;
      @(negedge sys_clk);
      reset_checks();
      chk("in reset", 24'h1, {23'h0, in_reset_q});
      repeat (6) @(posedge sys_clk);
      arst_n <= 1'b1;
      serve(55'h1, 7'h00, 7'h08, 24'h000014, HANDLER_BASE + 24'h000008, 4'h0);
      complete_run();
   end
   initial begin
      repeat (3000) @(posedge sys_clk);
      n_fail++;
      $display("Error watchdog expected done seen timeout");
      complete_run();
   end
endmodule
